// ===== logic/spm_serial_port.sv
/*
 one serial port channel: async 7/8/9-bit and address modes, sync shift
 mode, 15-bit baud generator, classic wishbone register slave.
 assumes rxd_in and bclk_pin are asynchronous and synchronised here.
*/
`timescale 1ns/100ps
`include "spm_regs.svh"
module spm_serial_port
    import spm_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rxd_in,
    output logic             rxd_out,
    output logic             rxd_oe_n,
    output logic             txd_pin,
    input  wire logic        bclk_pin
);
    logic [6:0]  ctrl;
    logic [14:0] baud_cnt;
    logic [15:0] baud_cmp;
    logic [8:0]  rxbuf;
    logic [7:0]  txhold;
    logic        txhold_full;
    logic        ri, ti, pe, fe, oe, rb8;
    logic [1:0]  rxd_sync, bclk_sync;
    logic        bclk_d;
    logic        baud_tick, tb_tick;
    logic        req, wr, rd;
    spm_tx_t     tx_st;
    spm_rx_t     rx_st;
    logic [2:0]  tx_ph, rx_ph;
    logic [3:0]  tx_n, rx_n;
    logic [9:0]  tx_sh;
    logic [8:0]  rx_sh;
    logic [2:0]  rx_votes;
    spm_mode_t   mode;
    logic        par_on;
    logic [3:0]  nbits;

    assign mode   = spm_mode_t'(ctrl[`SPM_CTRL_MODE_LSB +: 3]);
    // seven-bit and sync frames never carry parity
    assign par_on = ctrl[`SPM_CTRL_PEN] && mode != SPM_MODE_ASY7
                    && mode != SPM_MODE_SYNC;
    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr     = req && wb_we_i && wb_sel_i[0];
    assign rd     = req && !wb_we_i;

    function automatic logic [3:0] frame_bits(input spm_mode_t m);
        case (m)
            SPM_MODE_ASY7: frame_bits = 4'h7;
            SPM_MODE_ADDR,
            SPM_MODE_ASY9: frame_bits = 4'h9;
            default:       frame_bits = 4'h8;
        endcase
    endfunction : frame_bits
    assign nbits = frame_bits(mode);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxd_sync  <= 2'h0;
            bclk_sync <= 2'h0;
            bclk_d    <= 1'b0;
        end else begin
            rxd_sync  <= {rxd_sync[0], rxd_in};
            bclk_sync <= {bclk_sync[0], bclk_pin};
            bclk_d    <= bclk_sync[1];
        end
    end

    // timebase: cpu clock or rising edge of the synchronised pin
    assign tb_tick = baud_cmp[`SPM_BCMP_INTERNAL_TIMEBASE_SELECT] ? 1'b1
                     : (bclk_sync[1] && !bclk_d);
    assign baud_tick = tb_tick && (baud_cnt == baud_cmp[14:0]);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            baud_cnt <= `SPM_BAUD_RST;
        end else if (wr && wb_adr_i == `SPM_OFF_BCNT) begin
            baud_cnt <= wb_dat_i[14:0];
        end else if (baud_tick) begin
            baud_cnt <= `SPM_BAUD_RST;
        end else if (tb_tick) begin
            baud_cnt <= baud_cnt + 15'h0001;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            baud_cmp <= {1'b0, `SPM_BAUD_RST};
        end else if (wr && wb_adr_i == `SPM_OFF_BCMP) begin
            baud_cmp <= wb_dat_i[15:0];
        end
    end

    // tx_done strobes after a completed frame so the ninth bit clears
    logic tx_done;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= `SPM_CTRL_RST;
        end else if (wr && wb_adr_i == `SPM_OFF_CTRL) begin
            ctrl <= wb_dat_i[6:0];
        end else if (tx_done) begin
            ctrl[`SPM_CTRL_TB8] <= 1'b0;
        end
    end

    // load of tx shifter, value depends on mode and parity
    function automatic logic [8:0] tx_frame(input logic [7:0] d,
                                            input spm_mode_t m,
                                            input logic p,
                                            input logic ev,
                                            input logic tb8);
        logic [8:0] f;
        f = {1'b0, d};
        case (m)
            SPM_MODE_ASY7: f = {2'b00, d[6:0]};
            SPM_MODE_ASY8: if (p) f[7] = ^d[6:0] ^ ~ev;
            SPM_MODE_ADDR,
            SPM_MODE_ASY9: f[8] = p ? (^d ^ ~ev) : tb8;
            default:       f = {1'b0, d};
        endcase
        tx_frame = f;
    endfunction : tx_frame

    logic tx_load;
    // start on a baud pulse so the start bit lasts a whole bit
    assign tx_load = tx_st == SPM_TX_IDLE && txhold_full && baud_tick;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txhold      <= 8'h00;
            txhold_full <= 1'b0;
        end else if (wr && wb_adr_i == `SPM_OFF_TXHOLD) begin
            txhold      <= wb_dat_i[7:0];
            txhold_full <= 1'b1;
        end else if (tx_load) begin
            txhold_full <= 1'b0;
        end
    end

    // tx machine; sync mode reuses it to drive clock and data
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_st   <= SPM_TX_IDLE;
            tx_ph   <= 3'h0;
            tx_n    <= 4'h0;
            tx_sh   <= 10'h3FF;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            case (tx_st)
                SPM_TX_IDLE: if (tx_load) begin
                    // sync: dummy lsb, first clock fall presents bit 0
                    tx_sh <= (mode == SPM_MODE_SYNC)
                             ? {1'b1, txhold, 1'b1}
                             : {1'b1, tx_frame(txhold, mode, par_on,
                               ctrl[`SPM_CTRL_EVN], ctrl[`SPM_CTRL_TB8])};
                    tx_ph <= 3'h0;
                    tx_n  <= 4'h0;
                    tx_st <= (mode == SPM_MODE_SYNC) ? SPM_TX_DATA
                                                     : SPM_TX_START;
                end
                SPM_TX_START: if (baud_tick) begin
                    tx_ph <= tx_ph + 3'h1;
                    if (tx_ph == `SPM_OVERSAMPLE) tx_st <= SPM_TX_DATA;
                end
                SPM_TX_DATA: if (baud_tick) begin
                    // sync: one bit per baud pulse; async: eight pulses
                    tx_ph <= tx_ph + 3'h1;
                    if (mode == SPM_MODE_SYNC ||
                        tx_ph == `SPM_OVERSAMPLE) begin
                        tx_sh <= {1'b1, tx_sh[9:1]};
                        tx_n  <= tx_n + 4'h1;
                        tx_ph <= 3'h0;
                        if (tx_n == nbits - 4'h1) tx_st <= SPM_TX_STOP;
                    end
                end
                SPM_TX_STOP: if (baud_tick) begin
                    tx_ph <= tx_ph + 3'h1;
                    if (mode == SPM_MODE_SYNC ||
                        tx_ph == `SPM_OVERSAMPLE) begin
                        tx_st   <= SPM_TX_IDLE;
                        tx_done <= 1'b1;
                    end
                end
                default: tx_st <= SPM_TX_IDLE;
            endcase
        end
    end

    // sync shift clock: falls with the data change, rises a timebase
    // tick later so the peripheral sees settled data on the rise
    logic sync_clk;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_clk <= 1'b1;
        end else if (mode != SPM_MODE_SYNC) begin
            sync_clk <= 1'b1;
        end else if (baud_tick && ((tx_st == SPM_TX_DATA) ||
                                   (rx_st == SPM_RX_DATA))) begin
            sync_clk <= 1'b0;
        end else if (tb_tick) begin
            sync_clk <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txd_pin  <= 1'b1;
            rxd_out  <= 1'b1;
            rxd_oe_n <= 1'b1;
        end else if (mode == SPM_MODE_SYNC) begin
            txd_pin  <= sync_clk;
            rxd_out  <= tx_sh[0];
            // held through stop so the last bit stands at its clock rise
            rxd_oe_n <= !(tx_st == SPM_TX_DATA ||
                          tx_st == SPM_TX_STOP);
        end else begin
            txd_pin  <= (tx_st == SPM_TX_START) ? 1'b0
                        : (tx_st == SPM_TX_DATA) ? tx_sh[0] : 1'b1;
            rxd_out  <= 1'b1;
            rxd_oe_n <= 1'b1;
        end
    end

    // rx machine: majority of samples 3,4,5 of eight
    logic maj;
    assign maj = (rx_votes[0] & rx_votes[1]) | (rx_votes[0] & rx_votes[2])
                 | (rx_votes[1] & rx_votes[2]);
    logic rx_ok;
    logic [8:0] rx_word;
    assign rx_word = (mode == SPM_MODE_ASY7) ? {2'b00, rx_sh[8:2]}
                     : (nbits == 4'h8) ? {1'b0, rx_sh[8:1]} : rx_sh;
    logic rx_perr;
    // even parity leaves the whole word with an even count of ones
    assign rx_perr = par_on && ((^rx_word[8:0]) != !ctrl[`SPM_CTRL_EVN]);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_st    <= SPM_RX_IDLE;
            rx_ph    <= 3'h0;
            rx_n     <= 4'h0;
            rx_sh    <= 9'h000;
            rx_votes <= 3'h0;
            rx_ok    <= 1'b0;
        end else begin
            rx_ok <= 1'b0;
            if (baud_tick && rx_ph >= 3'h2 && rx_ph <= 3'h4)
                rx_votes <= {rx_votes[1:0], rxd_sync[1]};
            case (rx_st)
                SPM_RX_IDLE: begin
                    rx_ph <= 3'h0;
                    rx_n  <= 4'h0;
                    if (ctrl[`SPM_CTRL_REN] && mode == SPM_MODE_SYNC
                        && tx_st == SPM_TX_IDLE && !txhold_full
                        && !ri) begin
                        rx_st <= SPM_RX_DATA;
                    end else if (ctrl[`SPM_CTRL_REN] &&
                                 mode != SPM_MODE_SYNC && !rxd_sync[1]) begin
                        rx_st <= SPM_RX_START;
                    end
                end
                SPM_RX_START: if (baud_tick) begin
                    rx_ph <= rx_ph + 3'h1;
                    if (rx_ph == 3'h5 && maj) rx_st <= SPM_RX_IDLE;
                    if (rx_ph == `SPM_OVERSAMPLE) rx_st <= SPM_RX_DATA;
                end
                SPM_RX_DATA: if (baud_tick) begin
                    rx_ph <= rx_ph + 3'h1;
                    if (mode == SPM_MODE_SYNC ||
                        rx_ph == `SPM_OVERSAMPLE) begin
                        rx_sh <= {(mode == SPM_MODE_SYNC) ? rxd_sync[1] : maj,
                                  rx_sh[8:1]};
                        rx_n  <= rx_n + 4'h1;
                        rx_ph <= 3'h0;
                        if (rx_n == nbits - 4'h1) begin
                            rx_st <= (mode == SPM_MODE_SYNC) ? SPM_RX_IDLE
                                                             : SPM_RX_STOP;
                            rx_ok <= (mode == SPM_MODE_SYNC);
                        end
                    end
                end
                SPM_RX_STOP: if (baud_tick && rx_ph == 3'h5) begin
                    rx_st <= SPM_RX_IDLE;
                    rx_ok <= 1'b1;
                end else if (baud_tick) begin
                    rx_ph <= rx_ph + 3'h1;
                end
                default: rx_st <= SPM_RX_IDLE;
            endcase
        end
    end

    // stop validated mid-bit; address mode drops ninth-bit-zero frames
    logic rx_take, rx_stop_bad;
    assign rx_stop_bad = mode != SPM_MODE_SYNC && !maj;
    assign rx_take = rx_ok && !(mode == SPM_MODE_ADDR && !rx_word[8]);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxbuf <= 9'h000;
        end else if (rx_take) begin
            rxbuf <= rx_word;
        end
    end

    // set wins over the read-clear of status
    logic st_rd;
    assign st_rd = rd && wb_adr_i == `SPM_OFF_STATUS;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ri  <= 1'b0;
            ti  <= 1'b0;
            pe  <= 1'b0;
            fe  <= 1'b0;
            oe  <= 1'b0;
            rb8 <= 1'b0;
        end else begin
            ri  <= rx_take | (ri & !st_rd);
            ti  <= tx_done | (ti & !st_rd);
            oe  <= (rx_take & ri) | (oe & !st_rd);
            fe  <= (rx_take & rx_stop_bad) | (fe & !st_rd);
            pe  <= (rx_take & rx_perr) | (pe & !st_rd);
            if (rx_take) rb8 <= rx_word[8];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0000_0000;
            if (rd) begin
                case (wb_adr_i)
                    `SPM_OFF_RXBUF:  wb_dat_o[8:0] <= rxbuf;
                    `SPM_OFF_TXHOLD: wb_dat_o[7:0] <= txhold;
                    `SPM_OFF_CTRL:   wb_dat_o[6:0] <= ctrl;
                    `SPM_OFF_STATUS: wb_dat_o[5:0] <= {oe, fe,
                        par_on ? pe : rb8,
                        !txhold_full, ti, ri};
                    `SPM_OFF_BCNT:   wb_dat_o[14:0] <= baud_cnt;
                    `SPM_OFF_BCMP:   wb_dat_o[15:0] <= baud_cmp;
                    default:         wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : spm_serial_port

// ===== logic/spm_regs.svh
/*
 register offsets, field positions, reset values and timing constants
 of the serial port channel. assumes byte addresses on a 32-bit
 classic wishbone slave, one register per aligned word.
*/
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

`define SPM_OFF_RXBUF   6'h00
`define SPM_OFF_TXHOLD  6'h04
`define SPM_OFF_CTRL    6'h08
`define SPM_OFF_STATUS  6'h0C
`define SPM_OFF_BCNT    6'h10
`define SPM_OFF_BCMP    6'h14

`define SPM_CTRL_MODE_LSB 0
`define SPM_CTRL_PEN      3
`define SPM_CTRL_EVN      4
`define SPM_CTRL_REN      5
`define SPM_CTRL_TB8      6

`define SPM_ST_RI   0
`define SPM_ST_TI   1
`define SPM_ST_TXE  2
`define SPM_ST_PE   3
`define SPM_ST_FE   4
`define SPM_ST_OE   5

`define SPM_BCMP_INTERNAL_TIMEBASE_SELECT 15
`define SPM_CTRL_RST  7'h00
`define SPM_BAUD_RST  15'h0000
`define SPM_OVERSAMPLE 3'h7

`endif

// ===== logic/spm_pkg.sv
/*
 types of the serial port channel.
 assumes spm_regs.svh supplies numeric constants.
*/
package spm_pkg;
    typedef enum logic [2:0] {
        SPM_MODE_SYNC  = 3'h0,
        SPM_MODE_ASY8  = 3'h1,
        SPM_MODE_ADDR  = 3'h2,
        SPM_MODE_ASY9  = 3'h3,
        SPM_MODE_ASY7  = 3'h4
    } spm_mode_t;
    typedef enum {SPM_TX_IDLE, SPM_TX_START, SPM_TX_DATA, SPM_TX_STOP}
        spm_tx_t;
    typedef enum {SPM_RX_IDLE, SPM_RX_START, SPM_RX_DATA, SPM_RX_STOP}
        spm_rx_t;
endpackage : spm_pkg

// ===== testbench/spm_port_checker.sv
/*
 port checker of spm_serial_port: bus timing, readback, tx bit length.
 assumes writes land on the taking edge and the cpu clock as timebase.
*/
`timescale 1ns/100ps
`include "spm_regs.svh"
module spm_port_checker
    import spm_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        rxd_in,
    input wire logic        rxd_out,
    input wire logic        rxd_oe_n,
    input wire logic        txd_pin,
    input wire logic        bclk_pin
);
    logic [15:0] cmp;
    logic [5:0]  ctl;
    logic        rd_q;
    logic [5:0]  adr_q;
    logic        txd_q;
    int          run;
    int          blen;
    wire         take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire         async_m = ctl[2:0] != SPM_MODE_SYNC;
    assign blen = 8 * (int'(cmp[14:0]) + 1);
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmp <= 16'h0000;
            ctl <= 6'h00;
        end else if (take && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `SPM_OFF_BCMP) cmp <= wb_dat_i[15:0];
            if (wb_adr_i == `SPM_OFF_CTRL) ctl <= wb_dat_i[5:0];
        end
    end
    always_ff @(posedge core_clk) begin
        if (take) begin
            rd_q <= !wb_we_i;
            adr_q <= wb_adr_i;
        end
    end
    // in async mode, low runs on the line only ever span whole bits
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txd_q <= 1'b1;
            run <= 0;
        end else begin
            txd_q <= txd_pin;
            run <= (txd_pin != txd_q) ? 1 : run + 1;
        end
    end
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence rd_ans(logic [5:0] a);
        wb_ack_o && rd_q && adr_q == a;
    endsequence
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ack_timing_a: assert property (wb_req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    cmp_read_a: assert property (
        rd_ans(`SPM_OFF_BCMP) |-> wb_dat_o == {16'h0000, cmp})
        else $error("compare readback wrong");
    cnt_read_a: assert property (
        rd_ans(`SPM_OFF_BCNT) |-> wb_dat_o[31:15] == 17'h0
        && wb_dat_o[14:0] <= cmp[14:0])
        else $error("baud count beyond compare");
    mode_read_a: assert property (
        rd_ans(`SPM_OFF_CTRL) |-> wb_dat_o[5:0] == ctl)
        else $error("control readback wrong");
    oe_async_a: assert property (async_m |-> rxd_oe_n)
        else $error("data pin driven in async mode");
    bit_len_a: assert property (
        async_m && cmp[15] && $rose(txd_pin) |-> run % blen == 0)
        else $error("low run not a whole number of bits");
endmodule : spm_port_checker

// ===== testbench/spm_far_end.sv
/*
 far-end model: remote async port and shift-register peripheral.
 assumes the bench sets nbits before each frame; the data pin is pulled up.
*/
`timescale 1ns/100ps
module spm_far_end #(
    parameter int BIT_CLKS = 24
) (
    input  wire logic core_clk,
    input  wire logic txd_pin,
    input  wire logic rxd_oe_n,
    input  wire logic rxd_out,
    output wire logic rxd_line
);
    logic        drv = 1'b1;
    logic        clk_q = 1'b1;
    logic [10:0] frm = 11'h000;
    int          nbits = 0;
    int          frm_cnt = 0;
    int          pulses = 0;
    int          ones = 0;
    // released pin reads the far-end drive drv, which idles high
    assign rxd_line = rxd_oe_n ? drv : rxd_out;
    always begin
        @(negedge txd_pin);
        if (nbits > 0) begin
            frm = 11'h000;
            repeat (BIT_CLKS / 2) @(posedge core_clk);
            for (int i = 0; i <= nbits + 1; i++) begin
                if (i > 0) repeat (BIT_CLKS) @(posedge core_clk);
                frm[i] = txd_pin;
            end
            frm_cnt++;
        end
    end
    // order free count: bit order of the shift mode is left open
    always @(posedge core_clk) begin
        clk_q <= txd_pin;
        if (txd_pin && !clk_q && !rxd_oe_n) begin
            pulses++;
            ones += int'(rxd_out);
        end
    end
    task automatic send(input logic [8:0] w, input int n);
        @(posedge core_clk);
        drv <= 1'b0;
        for (int i = 0; i <= n; i++) begin
            repeat (BIT_CLKS) @(posedge core_clk);
            drv <= (i < n) ? w[i] : 1'b1;
        end
        repeat (BIT_CLKS) @(posedge core_clk);
    endtask : send
endmodule : spm_far_end

// ===== testbench/tb.sv
/*
 testbench of spm_serial_port: register, async tx/rx and sync tx tests.
 assumes compare 8002h, so one async bit lasts 24 clocks.
*/
`timescale 1ns/100ps
`include "spm_regs.svh"
module tb
    import spm_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [5:0]  wb_adr_i = 6'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic        bclk_pin = 1'b0;
    logic [1:0]  bdiv = 2'h0;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, rxd_in, rxd_out, rxd_oe_n, txd_pin;
    int          num_errors = 0;
    int          cmp_count = 0;
    logic [31:0] q;
    logic [7:0]  tx_ctl [8] = '{8'h01, 8'h19, 8'h09, 8'h1C, 8'h43, 8'h03,
                                8'h1B, 8'h42};
    logic [7:0]  tx_dat [8] = '{8'hA5, 8'h07, 8'h07, 8'h55, 8'hC3, 8'h3C,
                                8'h01, 8'h5A};
    logic [7:0]  rx_ctl [5] = '{8'h24, 8'h21, 8'h22, 8'h22, 8'h23};
    logic [8:0]  rx_w [5] = '{9'h055, 9'h0A5, 9'h0AA, 9'h1AA, 9'h033};
    always #25 core_clk = ~core_clk;
    // timebase kept at a quarter of the cpu clock
    always @(posedge core_clk) begin
        bdiv <= bdiv + 2'h1;
        bclk_pin <= bdiv[1];
    end
    spm_serial_port dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_in(rxd_in),
        .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd_pin(txd_pin),
        .bclk_pin(bclk_pin));
    spm_far_end #(.BIT_CLKS(24)) far_u (.core_clk(core_clk),
        .txd_pin(txd_pin), .rxd_oe_n(rxd_oe_n), .rxd_out(rxd_out),
        .rxd_line(rxd_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 16) chk(32'h1, 32'h0);
    endtask : wb
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] exp,
                      input logic [31:0] msk);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        chk(r & msk, exp);
    endtask : rd
    function automatic int nb(input logic [2:0] m);
        return (m == SPM_MODE_ASY7) ? 7 : (m == SPM_MODE_ASY8) ? 8 : 9;
    endfunction : nb
    function automatic logic [8:0] word_of(input logic [7:0] c,
                                           input logic [7:0] d);
        logic [8:0] w;
        w = {1'b0, d};
        if (nb(c[2:0]) == 7) w[7] = 1'b0;
        else if (nb(c[2:0]) == 9) w[8] = c[3] ? ^d ^ ~c[4] : c[6];
        else if (c[3]) w[7] = ^d[6:0] ^ ~c[4];
        return w;
    endfunction : word_of
    function automatic logic [10:0] frame_of(input logic [8:0] w,
                                             input int n);
        logic [10:0] f;
        f = 11'h000;
        for (int i = 0; i < n; i++) f[i + 1] = w[i];
        f[n + 1] = 1'b1;
        return f;
    endfunction : frame_of
    task automatic wrap_up;
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        wrap_up();
    end
    initial begin
        int k;
        int n;
        logic ok;
        logic [7:0] last;
        last = 8'h00;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(`SPM_OFF_CTRL, 32'h0, 32'h7F);
        rd(`SPM_OFF_BCMP, 32'h0, 32'hFFFF_FFFF);
        rd(`SPM_OFF_BCNT, 32'h0, 32'hFFFF_FFFF);
        wr(6'h18, 32'hFFFF_FFFF);
        rd(6'h18, 32'h0, 32'hFFFF_FFFF);
        wr(`SPM_OFF_BCMP, 32'h8002);
        rd(`SPM_OFF_BCMP, 32'h8002, 32'hFFFF_FFFF);
        for (int i = 0; i < 8; i++) begin
            wr(`SPM_OFF_CTRL, {24'h0, tx_ctl[i]});
            far_u.nbits = nb(tx_ctl[i][2:0]);
            k = far_u.frm_cnt;
            wr(`SPM_OFF_TXHOLD, {24'h0, tx_dat[i]});
            n = 0;
            while (far_u.frm_cnt == k && n < 2000) begin
                @(posedge core_clk);
                n++;
            end
            chk({21'h0, far_u.frm}, {21'h0, frame_of(word_of(tx_ctl[i],
                tx_dat[i]), far_u.nbits)});
            repeat (24) @(posedge core_clk);
            rd(`SPM_OFF_CTRL, 32'h0, 32'h40);
        end
        for (int i = 0; i < 5; i++) begin
            wr(`SPM_OFF_CTRL, {24'h0, rx_ctl[i]});
            wb(1'b0, `SPM_OFF_STATUS, 32'h0, q);
            n = nb(rx_ctl[i][2:0]);
            ok = !(rx_ctl[i][2:0] == SPM_MODE_ADDR && !rx_w[i][8]);
            far_u.send(rx_w[i], n);
            repeat (4) @(posedge core_clk);
            wb(1'b0, `SPM_OFF_STATUS, 32'h0, q);
            chk({29'h0, q[4], q[3], q[0]},
                {29'h0, 1'b0, ok && n == 9 && rx_w[i][8], ok});
            if (ok) last = rx_w[i][7:0] & ((n == 7) ? 8'h7F : 8'hFF);
            rd(`SPM_OFF_RXBUF, {24'h0, last},
               (n == 7) ? 32'h7F : 32'hFF);
        end
        far_u.nbits = 0;
        wr(`SPM_OFF_CTRL, 32'h0);
        repeat (100) @(posedge core_clk);
        chk(32'(far_u.pulses), 32'h0);
        wr(`SPM_OFF_TXHOLD, 32'h96);
        n = 0;
        q = 32'h0;
        while (q[1] !== 1'b1 && n < 100) begin
            wb(1'b0, `SPM_OFF_STATUS, 32'h0, q);
            n++;
        end
        repeat (4) @(posedge core_clk);
        chk(32'(far_u.pulses), 32'h8);
        chk(32'(far_u.ones), 32'h4);
        chk({31'h0, rxd_oe_n}, 32'h1);
        wrap_up();
    end
endmodule : tb
bind spm_serial_port spm_port_checker chk_u (.core_clk(core_clk),
    .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n),
    .txd_pin(txd_pin), .bclk_pin(bclk_pin));
